// *** hdl/udcs_device.sv ***
// udcs_device: command decoder, dma configuration, interrupt and endpoint status
`timescale 1ns/100ps
module udcs_device
    import udcs_pkg::*;
(
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    udcs_if.dev              bus,
    input  wire logic        i_end_of_transfer_in_n,
    input  wire logic        i_dma_done,
    input  wire logic        i_bus_reset,
    input  wire logic        i_suspend_change,
    input  wire logic        i_sof,
    input  wire logic        i_sof_only_mode,
    input  wire logic        i_nak_err_irq_mode,
    input  wire logic        i_txn_done,
    input  wire logic [2:0]  i_txn_ep,
    input  wire logic        i_txn_ok,
    input  wire logic [3:0]  i_txn_err,
    input  wire logic        i_txn_setup,
    input  wire logic        i_txn_toggle,
    input  wire logic [5:0]  i_ep_not_empty,
    input  wire logic [5:0]  i_ep_stalled,
    input  wire logic [5:0]  i_ep_ping_full,
    input  wire logic        i_pong_full,
    output logic [1:0]       o_dma_burst,
    output logic [4:0]       o_dma_burst_len,
    output logic             o_dma_enable,
    output logic             o_dma_direction,
    output logic             o_dma_auto_reload,
    output logic [1:0]       o_dma_skip_bytes,
    output logic [2:0]       o_endpoint_index
);
    import udcs_pkg::*;

    // ------------------------------------------------------------------
    // pin synchroniser for the end-of-transfer input
    // ------------------------------------------------------------------
    logic       eot_meta_n;
    logic       eot_sync_n;
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            eot_meta_n <= 1'b1;
            eot_sync_n <= 1'b1;
        end
        else
        begin
            eot_meta_n <= i_end_of_transfer_in_n;
            eot_sync_n <= eot_meta_n;
        end
    end
    wire eot_seen = ~eot_sync_n;

    // ------------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------------
    udcs_state_t state;
    udcs_kind_t  kind;
    logic [2:0]  ep_cmd;
    wire  [3:0]  cmd_hi   = bus.wdata[7:4];
    wire  [3:0]  cmd_lo   = bus.wdata[3:0];
    wire         idx_ok   = (cmd_lo <= EP_IDX_MAX);
    wire udcs_kind_t next_kind =
        (bus.wdata == CMD_DMA_CFG)          ? UDCS_K_DMA :
        (bus.wdata == CMD_IRQ_READ)         ? UDCS_K_IRQ :
        (cmd_hi == CMD_SEL_HI && idx_ok)    ? UDCS_K_SEL :
        (cmd_hi == CMD_LTS_HI && idx_ok)    ? UDCS_K_LTS :
        (cmd_hi == CMD_BUF_HI && idx_ok)    ? UDCS_K_BUF :
                                              UDCS_K_NONE;

    wire rd_dma   = bus.dat_rd && state == UDCS_ST_DATA1 && kind == UDCS_K_DMA;
    wire wr_dma   = bus.dat_wr && state == UDCS_ST_DATA1 && kind == UDCS_K_DMA;
    wire rd_irq1  = bus.dat_rd && state == UDCS_ST_DATA1 && kind == UDCS_K_IRQ;
    wire rd_irq2  = bus.dat_rd && state == UDCS_ST_DATA2 && kind == UDCS_K_IRQ;
    wire rd_lts   = bus.dat_rd && state == UDCS_ST_DATA1 && kind == UDCS_K_LTS;

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state  <= UDCS_ST_IDLE;
            kind   <= UDCS_K_NONE;
            ep_cmd <= 3'h0;
        end
        else if (bus.cmd_wr)
        begin
            kind   <= next_kind;
            ep_cmd <= cmd_lo[2:0];
            state  <= (next_kind == UDCS_K_NONE) ? UDCS_ST_IDLE : UDCS_ST_DATA1;
        end
        else if (bus.dat_rd || bus.dat_wr)
        begin
            case (state)
                UDCS_ST_DATA1: state <= rd_irq1 ? UDCS_ST_DATA2 : UDCS_ST_IDLE;
                UDCS_ST_DATA2: state <= UDCS_ST_IDLE;
                default:       state <= UDCS_ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // dma configuration
    // ------------------------------------------------------------------
    logic [7:0] dma_configuration;
    logic       dma_finish_d;
    wire        dma_finish = eot_seen | i_dma_done;
    wire        finish_edge = dma_finish & ~dma_finish_d;
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            dma_configuration <= DMA_CFG_RST;
            dma_finish_d      <= 1'b0;
        end
        else
        begin
            dma_finish_d <= dma_finish;
            if (wr_dma)
                dma_configuration <= bus.wdata;
            else if (eot_seen)
                dma_configuration[DMA_EN_BIT] <= 1'b0;
            else if (finish_edge && !dma_configuration[DMA_RELOAD_BIT])
                dma_configuration[DMA_EN_BIT] <= 1'b0;
        end
    end

    assign o_dma_burst       = dma_configuration[DMA_BURST_LSB +: 2];
    assign o_dma_burst_len   = (o_dma_burst == BURST_1) ? BURST_LEN_1 :
                               (o_dma_burst == BURST_4) ? BURST_LEN_4 :
                               (o_dma_burst == BURST_8) ? BURST_LEN_8 : BURST_LEN_16;
    assign o_dma_enable      = dma_configuration[DMA_EN_BIT];
    assign o_dma_direction   = dma_configuration[DMA_DIR_BIT];
    assign o_dma_auto_reload = dma_configuration[DMA_RELOAD_BIT];
    assign o_dma_skip_bytes  = o_dma_direction ? 2'h0 : DMA_SKIP_BYTES;

    // ------------------------------------------------------------------
    // per-endpoint transaction status and interrupt flags
    // ------------------------------------------------------------------
    logic [5:0] ep_flag;
    logic       bus_rst_flag;
    logic       susp_flag;
    wire  [7:0] irq_low = {susp_flag, bus_rst_flag, ep_flag};
    logic [7:0] irq_high;
    logic [6:0] lts     [NUM_EP];
    logic [5:0] lts_unread;
    logic [5:0] lts_ovwr;
    logic [2:0] endpoint_index;
    wire  is_nak_err = !i_txn_ok;
    wire  txn_irq    = i_txn_done && (!is_nak_err || i_nak_err_irq_mode);
    wire  irq_rd_any = rd_irq1;

    genvar g;
    generate
        for (g = 0; g < NUM_EP; g++)
        begin : g_ep
            wire hit  = i_txn_done && i_txn_ep == 3'(g);
            wire clr  = rd_lts && ep_cmd == 3'(g);
            wire ie   = (g == 4) ? dma_configuration[DMA_IE4_BIT] :
                        (g == 5) ? dma_configuration[DMA_IE5_BIT] : 1'b1;
            always_ff @(posedge i_core_clk or posedge i_rst)
            begin
                if (i_rst)
                begin
                    lts[g]        <= LTS_RST;
                    lts_unread[g] <= 1'b0;
                    lts_ovwr[g]   <= 1'b0;
                    ep_flag[g]    <= 1'b0;
                end
                else
                begin
                    if (hit)
                    begin
                        lts[g]        <= {i_txn_toggle, i_txn_setup, i_txn_err, i_txn_ok};
                        lts_unread[g] <= 1'b1;
                        lts_ovwr[g]   <= lts_unread[g] & ~clr;
                    end
                    else if (clr)
                    begin
                        lts_unread[g] <= 1'b0;
                        lts_ovwr[g]   <= 1'b0;
                    end
                    // set wins over clear
                    if (hit && txn_irq && ie)
                        ep_flag[g] <= 1'b1;
                    else if (clr)
                        ep_flag[g] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            bus_rst_flag            <= 1'b0;
            susp_flag               <= 1'b0;
            irq_high                <= IRQ_RST;
            endpoint_index          <= 3'h0;
        end
        else
        begin
            if (i_bus_reset)
                bus_rst_flag <= 1'b1;
            else if (irq_rd_any)
                bus_rst_flag <= 1'b0;
            if (i_suspend_change)
                susp_flag <= 1'b1;
            else if (irq_rd_any)
                susp_flag <= 1'b0;
            // byte2 clears on its own read, else a two-byte read never sees it
            if (finish_edge)
                irq_high[IRQ_DMAEND_BIT] <= 1'b1;
            else if (rd_irq2)
                irq_high[IRQ_DMAEND_BIT] <= 1'b0;
            if (bus.cmd_wr && next_kind == UDCS_K_SEL)
                endpoint_index <= cmd_lo[2:0];
        end
    end
    assign o_endpoint_index = endpoint_index;

    // ------------------------------------------------------------------
    // read data and interrupt pin
    // ------------------------------------------------------------------
    wire [7:0] sel_byte = {6'h00, i_ep_stalled[ep_cmd], i_ep_not_empty[ep_cmd]};
    wire [7:0] lts_byte = {lts_ovwr[ep_cmd], lts[ep_cmd]};
    wire       pong_ok  = (ep_cmd == PONG_EP_OUT[2:0]) || (ep_cmd == PONG_EP_IN[2:0]);
    wire [7:0] buf_byte = {i_ep_stalled[ep_cmd], i_pong_full & pong_ok,
                           i_ep_ping_full[ep_cmd], 2'h0,
                           lts[ep_cmd][LTS_SETUP_BIT], 2'h0};
    wire [7:0] next_rdata =
        (state == UDCS_ST_DATA2)  ? irq_high :
        (kind == UDCS_K_DMA)      ? dma_configuration :
        (kind == UDCS_K_IRQ)      ? irq_low :
        (kind == UDCS_K_SEL)      ? sel_byte :
        (kind == UDCS_K_LTS)      ? lts_byte :
        (kind == UDCS_K_BUF)      ? buf_byte : 8'h00;

    logic [7:0] rdata_q;
    logic       irq_q;
    wire        flag_any = |irq_low | irq_high[IRQ_DMAEND_BIT];
    wire        sof_irq  = i_sof && (i_sof_only_mode || dma_configuration[DMA_SOFPIN_BIT]);
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            rdata_q <= 8'h00;
            irq_q   <= 1'b0;
        end
        else
        begin
            rdata_q <= next_rdata;
            irq_q   <= i_sof_only_mode ? i_sof : (flag_any | sof_irq);
        end
    end
    assign bus.rdata = rdata_q;
    assign bus.irq   = irq_q;

endmodule : udcs_device

// *** hdl/udcs_host.sv ***
// udcs_host: microcontroller-side sequencer issuing commands and data bytes
`timescale 1ns/100ps
module udcs_host
    import udcs_pkg::*;
(
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    udcs_if.host             bus,
    input  wire logic        i_req,
    input  wire logic [7:0]  i_cmd,
    input  wire logic [1:0]  i_nbytes,
    input  wire logic        i_write,
    input  wire logic [7:0]  i_wdata,
    output logic             o_busy,
    output logic             o_done,
    output logic [7:0]       o_rdata0,
    output logic [7:0]       o_rdata1,
    output logic             o_irq
);
    import udcs_pkg::*;

    // ------------------------------------------------------------------
    // sequencer: command, then 0..3 data strobes, with a capture after each read strobe
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        UDCS_H_IDLE = 3'b000,
        UDCS_H_CMD  = 3'b001,
        UDCS_H_DAT  = 3'b011,
        UDCS_H_CAP  = 3'b010,
        UDCS_H_FIN  = 3'b110
    } udcs_hstate_t;

    udcs_hstate_t hs;
    logic [7:0]   cmd_q;
    logic [7:0]   wdat_q;
    logic [1:0]   left;
    logic         wr_q;
    logic         second;

    // a DMA config write must keep index 4/5 interrupts as the caller chose;
    // advice is left to firmware, since forcing it would hide intent
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            hs       <= UDCS_H_IDLE;
            cmd_q    <= 8'h00;
            wdat_q   <= 8'h00;
            left     <= 2'h0;
            wr_q     <= 1'b0;
            second   <= 1'b0;
            o_rdata0 <= 8'h00;
            o_rdata1 <= 8'h00;
        end
        else
        begin
            case (hs)
                UDCS_H_IDLE:
                    if (i_req)
                    begin
                        cmd_q  <= i_cmd;
                        wdat_q <= i_wdata;
                        left   <= (i_cmd == CMD_IRQ_READ) ? i_nbytes : {1'b0, |i_nbytes};
                        wr_q   <= i_write;
                        second <= 1'b0;
                        hs     <= UDCS_H_CMD;
                    end
                UDCS_H_CMD:
                    hs <= (left == 2'h0) ? UDCS_H_FIN : UDCS_H_DAT;
                UDCS_H_DAT:
                    hs <= wr_q ? UDCS_H_FIN : UDCS_H_CAP;
                UDCS_H_CAP:
                begin
                    if (second)
                        o_rdata1 <= bus.rdata;
                    else
                        o_rdata0 <= bus.rdata;
                    second <= 1'b1;
                    left   <= left - 2'h1;
                    hs     <= (left == 2'h1) ? UDCS_H_FIN : UDCS_H_DAT;
                end
                UDCS_H_FIN:
                    hs <= UDCS_H_IDLE;
                default:
                    hs <= UDCS_H_IDLE;
            endcase
        end
    end

    assign bus.cmd_wr = (hs == UDCS_H_CMD);
    assign bus.dat_wr = (hs == UDCS_H_DAT) && wr_q;
    assign bus.dat_rd = (hs == UDCS_H_DAT) && !wr_q;
    assign bus.wdata  = (hs == UDCS_H_CMD) ? cmd_q : wdat_q;
    assign o_busy     = (hs != UDCS_H_IDLE);
    assign o_done     = (hs == UDCS_H_FIN);
    // same clock and already registered in the device, so no synchroniser
    assign o_irq      = bus.irq;

endmodule : udcs_host

// *** inc/udcs_if.sv ***
// udcs_if: 8-bit command bus between microcontroller and device
`timescale 1ns/100ps
interface udcs_if;
    logic       cmd_wr;
    logic       dat_wr;
    logic       dat_rd;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       irq;

    modport dev
    (
        input  cmd_wr,
        input  dat_wr,
        input  dat_rd,
        input  wdata,
        output rdata,
        output irq
    );

    modport host
    (
        output cmd_wr,
        output dat_wr,
        output dat_rd,
        output wdata,
        input  rdata,
        input  irq
    );
endinterface : udcs_if

// *** inc/udcs_pkg.sv ***
// udcs_pkg: shared constants and types for the usb device command/status block
package udcs_pkg;

    // ------------------------------------------------------------------
    // command codes
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_DMA_CFG     = 8'hfb;
    localparam logic [7:0] CMD_IRQ_READ    = 8'hf4;
    localparam logic [3:0] CMD_SEL_HI      = 4'h0;
    localparam logic [3:0] CMD_LTS_HI      = 4'h4;
    localparam logic [3:0] CMD_BUF_HI      = 4'h8;
    localparam logic [3:0] EP_IDX_MAX      = 4'h5;
    localparam int         NUM_EP          = 6;

    // ------------------------------------------------------------------
    // dma configuration fields and reset value
    // ------------------------------------------------------------------
    localparam int         DMA_BURST_LSB   = 0;
    localparam int         DMA_EN_BIT      = 2;
    localparam int         DMA_DIR_BIT     = 3;
    localparam int         DMA_RELOAD_BIT  = 4;
    localparam int         DMA_SOFPIN_BIT  = 5;
    localparam int         DMA_IE4_BIT     = 6;
    localparam int         DMA_IE5_BIT     = 7;
    localparam logic [7:0] DMA_CFG_RST     = 8'h00;
    localparam logic [1:0] BURST_1         = 2'h0;
    localparam logic [1:0] BURST_4         = 2'h1;
    localparam logic [1:0] BURST_8         = 2'h2;
    localparam logic [1:0] BURST_16        = 2'h3;
    localparam logic [4:0] BURST_LEN_1     = 5'h01;
    localparam logic [4:0] BURST_LEN_4     = 5'h04;
    localparam logic [4:0] BURST_LEN_8     = 5'h08;
    localparam logic [4:0] BURST_LEN_16    = 5'h10;
    localparam logic [1:0] DMA_SKIP_BYTES  = 2'h2;

    // ------------------------------------------------------------------
    // interrupt byte positions
    // ------------------------------------------------------------------
    localparam int         IRQ_BUSRST_BIT  = 6;
    localparam int         IRQ_SUSP_BIT    = 7;
    localparam int         IRQ_DMAEND_BIT  = 0;
    localparam logic [7:0] IRQ_RST         = 8'h00;

    // ------------------------------------------------------------------
    // status byte positions
    // ------------------------------------------------------------------
    localparam int         LTS_OK_BIT      = 0;
    localparam int         LTS_ERR_LSB     = 1;
    localparam int         LTS_SETUP_BIT   = 5;
    localparam int         LTS_TOGGLE_BIT  = 6;
    localparam int         LTS_OVWR_BIT    = 7;
    localparam int         BUF_SETUP_BIT   = 2;
    localparam int         BUF_PING_BIT    = 5;
    localparam int         BUF_PONG_BIT    = 6;
    localparam int         BUF_STALL_BIT   = 7;
    localparam int         PONG_EP_OUT     = 4;
    localparam int         PONG_EP_IN      = 5;
    localparam logic [6:0] LTS_RST         = 7'h00;

    typedef enum logic [3:0] {
        UDCS_ERR_NONE     = 4'h0,
        UDCS_ERR_PID_ENC  = 4'h1,
        UDCS_ERR_PID_UNK  = 4'h2,
        UDCS_ERR_UNEXP    = 4'h3,
        UDCS_ERR_TOK_CRC  = 4'h4,
        UDCS_ERR_DAT_CRC  = 4'h5,
        UDCS_ERR_TIMEOUT  = 4'h6,
        UDCS_ERR_EOP      = 4'h8,
        UDCS_ERR_NAK      = 4'h9,
        UDCS_ERR_STALL    = 4'ha,
        UDCS_ERR_OVERFLOW = 4'hb,
        UDCS_ERR_STUFF    = 4'hd,
        UDCS_ERR_DATA_PID = 4'hf
    } udcs_err_t;

    // command decoder states, gray along idle -> data1 -> data2
    typedef enum logic [1:0] {
        UDCS_ST_IDLE  = 2'b00,
        UDCS_ST_DATA1 = 2'b01,
        UDCS_ST_DATA2 = 2'b11
    } udcs_state_t;

    typedef enum logic [2:0] {
        UDCS_K_NONE = 3'h0,
        UDCS_K_DMA  = 3'h1,
        UDCS_K_IRQ  = 3'h2,
        UDCS_K_SEL  = 3'h3,
        UDCS_K_LTS  = 3'h4,
        UDCS_K_BUF  = 3'h5
    } udcs_kind_t;

endpackage : udcs_pkg

// *** test/udcs_chk.sv ***
// udcs_chk: assertions on the command bus between host and device
`timescale 1ns/100ps
module udcs_chk
    import udcs_pkg::*;
(
    input  wire logic       i_core_clk,
    input  wire logic       i_rst,
    input  wire logic       cmd_wr,
    input  wire logic       dat_wr,
    input  wire logic       dat_rd,
    input  wire logic [7:0] wdata,
    input  wire logic [7:0] rdata,
    input  wire logic       irq
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    logic [1:0] rd_cnt;
    logic       two_ok;
    wire        ep_ok = wdata[3:0] <= EP_IDX_MAX;
    wire        known = wdata == CMD_DMA_CFG || wdata == CMD_IRQ_READ
                      || (wdata[7:4] inside {CMD_SEL_HI, CMD_LTS_HI, CMD_BUF_HI} && ep_ok);
    // reads since the last command; only the interrupt command allows a second one
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            rd_cnt <= 2'h0;
        else if (cmd_wr)
            rd_cnt <= 2'h0;
        else if (dat_rd && rd_cnt != 2'h3)
            rd_cnt <= rd_cnt + 2'h1;
    end
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            two_ok <= 1'b0;
        else if (cmd_wr)
            two_ok <= wdata == CMD_IRQ_READ;
    end
    sequence s_sel;
        cmd_wr && wdata[7:4] == CMD_SEL_HI && ep_ok;
    endsequence
    sequence s_buf;
        cmd_wr && wdata[7:4] == CMD_BUF_HI && ep_ok;
    endsequence
    AST_ONE_STROBE: assert property ($onehot0({cmd_wr, dat_wr, dat_rd}))
        else $error("two bus strobes in one cycle");
    AST_CMD_PULSE: assert property (cmd_wr |=> !cmd_wr)
        else $error("command strobe longer than one cycle");
    AST_RD_PULSE: assert property (dat_rd |=> !dat_rd)
        else $error("read strobe longer than one cycle");
    AST_WR_DMA_ONLY: assert property (dat_wr |-> $past(cmd_wr) && $past(wdata) == CMD_DMA_CFG)
        else $error("data write not right after configuration command");
    AST_RD_COUNT: assert property (dat_rd |-> rd_cnt < (two_ok ? 2'h2 : 2'h1))
        else $error("too many data reads for command");
    // rdata shows the addressed byte one cycle after the command edge
    AST_SEL_RSVD: assert property (s_sel |=> ##1 rdata[7:2] == 6'h00)
        else $error("endpoint select status reserved bits set");
    AST_BUF_RSVD: assert property (s_buf |=> ##1 rdata[4:3] == 2'h0 && rdata[1:0] == 2'h0)
        else $error("buffer status reserved bits set");
    AST_PONG_EP2: assert property (s_buf and wdata[3:0] < 4'h4 |=> ##1 !rdata[6])
        else $error("pong flag on endpoint without pong buffer");
    AST_REFUSED: assert property (cmd_wr && !known |=> ##1 rdata == 8'h00)
        else $error("unknown command returned data");
endmodule : udcs_chk

// *** test/usb_dev_dma_irq_ep_status_tb.sv ***
// usb_dev_dma_irq_ep_status_tb: host and device joined, driven from the user side
`timescale 1ns/100ps
module usb_dev_dma_irq_ep_status_tb;
    import udcs_pkg::*;
    logic       core_clk = 1'b0, rst = 1'b1, req = 1'b0, wr = 1'b0, end_of_transfer_in = 1'b1;
    logic       sof_only = 1'b0, nak_mode = 1'b0, pong = 1'b1, irq_hit = 1'b0;
    logic       t_ok = 1'b0, t_setup = 1'b0, t_tog = 1'b0;
    logic [1:0] nbytes = 2'h0;
    logic [2:0] t_ep = 3'h0;
    logic [3:0] t_err = 4'h0;
    logic [4:0] ev = 5'h00;
    logic [5:0] ep_ne = 6'h15, ep_st = 6'h2a, ep_ping = 6'h33;
    logic [7:0] cmd = 8'h00, wdat = 8'h00;
    logic [7:0] cfgs [4] = '{8'h00, 8'h19, 8'h02, 8'h0b};
    logic [4:0] blen [4] = '{5'h01, 5'h04, 5'h08, 5'h10};
    logic [3:0] codes [13] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9,
                               4'ha, 4'hb, 4'hd, 4'hf};
    wire  logic busy, done, hirq, en, dir, rel;
    wire  logic [1:0] burst, skip;
    wire  logic [2:0] ep_idx;
    wire  logic [4:0] len;
    wire  logic [7:0] rdat0, rdat1;
    int         error_cnt = 0, comparisons = 0, cyc = 0;

    udcs_if bus_if ();
    udcs_device udcs_device_i (.i_core_clk(core_clk), .i_rst(rst), .bus(bus_if),
        .i_end_of_transfer_in_n(end_of_transfer_in), .i_dma_done(ev[0]), .i_bus_reset(ev[1]),
        .i_suspend_change(ev[2]), .i_sof(ev[3]), .i_sof_only_mode(sof_only),
        .i_nak_err_irq_mode(nak_mode), .i_txn_done(ev[4]), .i_txn_ep(t_ep), .i_txn_ok(t_ok),
        .i_txn_err(t_err), .i_txn_setup(t_setup), .i_txn_toggle(t_tog), .i_ep_not_empty(ep_ne),
        .i_ep_stalled(ep_st), .i_ep_ping_full(ep_ping), .i_pong_full(pong),
        .o_dma_burst(burst), .o_dma_burst_len(len), .o_dma_enable(en), .o_dma_direction(dir),
        .o_dma_auto_reload(rel), .o_dma_skip_bytes(skip), .o_endpoint_index(ep_idx));
    udcs_host udcs_host_i (.i_core_clk(core_clk), .i_rst(rst), .bus(bus_if), .i_req(req),
        .i_cmd(cmd), .i_nbytes(nbytes), .i_write(wr), .i_wdata(wdat), .o_busy(busy),
        .o_done(done), .o_rdata0(rdat0), .o_rdata1(rdat1), .o_irq(hirq));
    udcs_chk udcs_chk_i (.i_core_clk(core_clk), .i_rst(rst), .cmd_wr(bus_if.cmd_wr),
        .dat_wr(bus_if.dat_wr), .dat_rd(bus_if.dat_rd), .wdata(bus_if.wdata),
        .rdata(bus_if.rdata), .irq(bus_if.irq));

    // ------------------------------------------------------------------
    // clock, timeout and shared tasks
    // ------------------------------------------------------------------
    initial
    begin
        forever #10 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        if (error_cnt == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic xfer(input logic [7:0] c, input logic [1:0] n, input logic w,
                        input logic [7:0] d);
        @(posedge core_clk);
        #1;
        {req, cmd, nbytes, wr, wdat} = {1'b1, c, n, w, d};
        @(posedge core_clk);
        #1;
        req = 1'b0;
        // done is a one-cycle pulse, so look for it between edges
        for (int k = 0; k < 20 && done !== 1'b1; k++)
            @(negedge core_clk);
        check({6'h0, busy, done}, 8'h03);
        @(posedge core_clk);
        #1;
    endtask : xfer
    task automatic rd1(input logic [7:0] c, input logic [7:0] exp);
        xfer(c, 2'h1, 1'b0, 8'h00);
        check(rdat0, exp);
    endtask : rd1
    task automatic pulse(input logic [4:0] m);
        @(posedge core_clk);
        #1;
        ev = m;
        irq_hit = 1'b0;
        @(posedge core_clk);
        #1;
        ev = 5'h00;
        repeat (8) @(negedge core_clk) irq_hit |= hirq;
        @(posedge core_clk);
        #1;
    endtask : pulse
    task automatic txn(input logic [2:0] e, input logic ok, input logic [3:0] er,
                       input logic s, input logic t);
        @(posedge core_clk);
        #1;
        {t_ep, t_ok, t_err, t_setup, t_tog} = {e, ok, er, s, t};
        pulse(5'h10);
    endtask : txn

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (3) @(posedge core_clk);
        #1;
        rst = 1'b0;
        rd1(CMD_DMA_CFG, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            xfer(CMD_DMA_CFG, 2'h1, 1'b1, cfgs[i]);
            check({rel, dir, en, len}, {cfgs[i][4:2], blen[i]});
            check({4'h0, burst, skip}, {4'h0, cfgs[i][1:0], cfgs[i][3] ? 2'h0 : 2'h2});
            rd1(CMD_DMA_CFG, cfgs[i]);
        end
        xfer(CMD_DMA_CFG, 2'h1, 1'b1, 8'h14);
        @(posedge core_clk);
        #1;
        end_of_transfer_in = 1'b0;
        repeat (4) @(posedge core_clk);
        #1;
        end_of_transfer_in = 1'b1;
        check({7'h0, en}, 8'h00);
        xfer(CMD_IRQ_READ, 2'h2, 1'b0, 8'h00);
        xfer(CMD_DMA_CFG, 2'h1, 1'b1, 8'h14);
        pulse(5'h01);
        check({7'h0, en}, 8'h01);
        xfer(CMD_IRQ_READ, 2'h2, 1'b0, 8'h00);
        check(rdat1, 8'h01);
        xfer(CMD_IRQ_READ, 2'h2, 1'b0, 8'h00);
        check(rdat1, 8'h00);
        xfer(CMD_DMA_CFG, 2'h1, 1'b1, 8'h04);
        pulse(5'h01);
        check({7'h0, en}, 8'h00);
        xfer(CMD_IRQ_READ, 2'h2, 1'b0, 8'h00);
        xfer(CMD_DMA_CFG, 2'h1, 1'b1, 8'h00);
        pulse(5'h06);
        check({7'h0, irq_hit}, 8'h01);
        rd1(CMD_IRQ_READ, 8'hc0);
        rd1(CMD_IRQ_READ, 8'h00);
        pulse(5'h08);
        check({7'h0, irq_hit}, 8'h00);
        xfer(CMD_DMA_CFG, 2'h1, 1'b1, 8'h20);
        pulse(5'h08);
        check({7'h0, irq_hit}, 8'h01);
        xfer(CMD_DMA_CFG, 2'h1, 1'b1, 8'h00);
        @(posedge core_clk);
        #1;
        sof_only = 1'b1;
        pulse(5'h02);
        check({7'h0, irq_hit}, 8'h00);
        pulse(5'h08);
        check({7'h0, irq_hit}, 8'h01);
        sof_only = 1'b0;
        rd1(CMD_IRQ_READ, 8'h40);
        // second status before any read marks the first as overwritten
        txn(3'h0, 1'b1, 4'h0, 1'b0, 1'b1);
        txn(3'h0, 1'b1, 4'h0, 1'b1, 1'b0);
        rd1(CMD_IRQ_READ, 8'h01);
        rd1(8'h40, 8'ha1);
        rd1(CMD_IRQ_READ, 8'h00);
        rd1(8'h40, 8'h21);
        nak_mode = 1'b1;
        for (int i = 0; i < 13; i++)
        begin
            txn(3'h1, 1'b0, codes[i], 1'b0, 1'b1);
            rd1(CMD_IRQ_READ, 8'h02);
            rd1(8'h41, {3'b010, codes[i], 1'b0});
        end
        nak_mode = 1'b0;
        txn(3'h1, 1'b0, 4'h9, 1'b0, 1'b0);
        rd1(CMD_IRQ_READ, 8'h00);
        rd1(8'h41, 8'h12);
        txn(3'h4, 1'b1, 4'h0, 1'b0, 1'b0);
        rd1(CMD_IRQ_READ, 8'h00);
        rd1(8'h44, 8'h01);
        xfer(CMD_DMA_CFG, 2'h1, 1'b1, 8'hc0);
        txn(3'h5, 1'b1, 4'h0, 1'b0, 1'b0);
        rd1(CMD_IRQ_READ, 8'h20);
        rd1(8'h45, 8'h01);
        for (int e = 0; e < 6; e++)
        begin
            rd1({4'h0, e[3:0]}, {6'h00, ep_st[e], ep_ne[e]});
            check({5'h00, ep_idx}, e[7:0]);
            rd1({4'h8, e[3:0]}, {ep_st[e], pong && e > 3, ep_ping[e], 2'h0, e == 0, 2'h0});
        end
        rd1(8'h06, 8'h00);
        report_and_stop();
    end
endmodule : usb_dev_dma_irq_ep_status_tb
